// [hdl/dhot_top.sv]
// Two-channel converter holding/output register block with AXI4-Lite access
//
// Behaviour
// - Two identical independent converters, 10-bit data, one interrupt line each.
// - Output value is read-only; it loads only from the holding value.
// - Trigger disabled: holding value copies to output one clock after write.
// - Trigger enabled: copy latest holding value on each selected timer rising edge.
// - Select field bits 3..1 pick timer outputs 0..5; codes 11x reserved.
// - Mode bit 4 selects 8-bit when 1, 10-bit when 0; resets 10-bit.
// - In 8-bit mode written byte is stored shifted left two, low bits zero.
// - Data channel writes one byte in 8-bit mode, a half-word in 10-bit.
// - Holding value reads back adjusted data, upper bits zero.
// - Output value reads right-aligned in bits 9..0, other bits zero.
// - Ready flag clears on holding write, sets when a timer trigger moves the value to output.
// - Ready reads 0 at reset and with trigger off; enabling trigger sets it.
// - Ready flag can raise the converter interrupt line.
// - Command bit 0 written 1 resets the converter; 0 has no effect.
// - Enable/disable registers set/clear the ready mask; mask register reads it.
`timescale 1ns/1ps
`default_nettype none

module dhot_top
  import dhot_pkg::*;
#(
  parameter int ADDR_W = 7                               // Bus address width
)(
  input  wire logic                 i_core_clk,          // Master clock
  input  wire logic                 i_rst_n,             // Async reset, active low
  input  wire logic [TIMER_N-1:0]   i_timer_wave_output_a, // Timer trigger sources
  output logic      [DATA_W-1:0]    o_dor0,              // Converter 0 output value
  output logic      [DATA_W-1:0]    o_dor1,              // Converter 1 output value
  output logic                      o_converter0_irq,    // Converter 0 interrupt
  output logic                      o_converter1_irq,    // Converter 1 interrupt
  input  wire logic [ADDR_W-1:0]    i_s_axi_awaddr,      // Write address
  input  wire logic                 i_s_axi_awvalid,     // Write address valid
  output logic                      o_s_axi_awready,     // Write address ready
  input  wire logic [AXI_DW-1:0]    i_s_axi_wdata,       // Write data
  input  wire logic [AXI_SW-1:0]    i_s_axi_wstrb,       // Write strobes
  input  wire logic                 i_s_axi_wvalid,      // Write data valid
  output logic                      o_s_axi_wready,      // Write data ready
  output logic      [1:0]           o_s_axi_bresp,       // Write response
  output logic                      o_s_axi_bvalid,      // Write response valid
  input  wire logic                 i_s_axi_bready,      // Write response ready
  input  wire logic [ADDR_W-1:0]    i_s_axi_araddr,      // Read address
  input  wire logic                 i_s_axi_arvalid,     // Read address valid
  output logic                      o_s_axi_arready,     // Read address ready
  output logic      [AXI_DW-1:0]    o_s_axi_rdata,       // Read data
  output logic      [1:0]           o_s_axi_rresp,       // Read response
  output logic                      o_s_axi_rvalid,      // Read data valid
  input  wire logic                 i_s_axi_rready       // Read data ready
);
  import dhot_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < CH_BIT + 1) begin : g_bad_addr
    $error("ADDR_W too small for two converter windows");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MR_W-1:0]   mode;
    logic [DATA_W-1:0] hold;
    logic [DATA_W-1:0] dout;
    logic              pend;     // Auto-mode copy due next clock
    logic              rdy;
    logic [IM_W-1:0]   mask;
    logic              evt;      // Sticky transfer event
    logic              irq;
  } dhot_chan_t;

  typedef struct packed {
    dhot_chan_t [CONV_N-1:0] chan;
    logic [TIMER_N-1:0]      tprev;
    logic                    aw_held;
    logic [ADDR_W-1:0]       aw_addr;
    logic                    w_held;
    logic [AXI_DW-1:0]       w_data;
    logic [AXI_SW-1:0]       w_strb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [AXI_DW-1:0]       rdata;
    logic [1:0]              rresp;
  } dhot_state_t;

  dhot_state_t q_reg;
  dhot_state_t q_next;

  // Per-channel, per-timer and bus strobes exported for the checks below
  logic [CONV_N-1:0]  xfer_w;
  logic [CONV_N-1:0]  hold_wr_w;
  logic [CONV_N-1:0]  srst_w;
  logic [CONV_N-1:0]  ien_w;
  logic [TIMER_N-1:0] edge_w;
  logic               wr_go_w;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus, transfer engine and read mux in one place so that a write and
  // a trigger landing in the same clock resolve in a fixed order.
  always_comb
  begin
    logic              wch;
    logic [OFF_W-1:0]  woff;
    logic              wok;
    logic              rch;
    logic [OFF_W-1:0]  roff;
    logic              rok;
    logic [AXI_DW-1:0] rval;
    logic [2:0]        sel;
    logic              mine;
    wch     = q_reg.aw_addr[CH_BIT];
    woff    = q_reg.aw_addr[OFF_W-1:0];
    wok     = ((q_reg.aw_addr >> (CH_BIT + 1)) == '0) && ((woff & ALIGN_MASK) == '0)
              && (woff <= OFF_EVENT);
    rch     = i_s_axi_araddr[CH_BIT];
    roff    = i_s_axi_araddr[OFF_W-1:0];
    rok     = ((i_s_axi_araddr >> (CH_BIT + 1)) == '0) && ((roff & ALIGN_MASK) == '0)
              && (roff <= OFF_EVENT);
    rval    = '0;
    sel     = '0;
    mine    = 1'b0;
    q_next  = q_reg;
    xfer_w  = '0;
    hold_wr_w = '0;
    srst_w  = '0;
    ien_w   = '0;
    edge_w  = i_timer_wave_output_a & ~q_reg.tprev;
    wr_go_w = q_reg.aw_held && q_reg.w_held && !q_reg.bvalid;
    q_next.tprev = i_timer_wave_output_a;

    // Write channels: one-cycle ready pulses, each side latched on its own
    q_next.awready = i_s_axi_awvalid && !q_reg.aw_held && !q_reg.awready && !q_reg.bvalid;
    q_next.wready  = i_s_axi_wvalid && !q_reg.w_held && !q_reg.wready && !q_reg.bvalid;
    if (i_s_axi_awvalid && q_reg.awready)
    begin
      q_next.aw_held = 1'b1;
      q_next.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && q_reg.wready)
    begin
      q_next.w_held = 1'b1;
      q_next.w_data = i_s_axi_wdata;
      q_next.w_strb = i_s_axi_wstrb;
    end
    if (q_reg.bvalid && i_s_axi_bready)
    begin
      q_next.bvalid = 1'b0;
    end
    if (wr_go_w)
    begin
      q_next.aw_held = 1'b0;
      q_next.w_held  = 1'b0;
      q_next.bvalid  = 1'b1;
      q_next.bresp   = wok ? RESP_OKAY : RESP_SLVERR;
    end

    // Converter channels, identical and independent
    for (int c = 0; c < CONV_N; c++)
    begin
      mine = wr_go_w && wok && (wch == 1'(c));
      sel  = q_reg.chan[c].mode[MR_SEL_MSB:MR_SEL_LSB];
      // Transfer source: pending auto copy, or a selected timer edge
      if (!q_reg.chan[c].mode[MR_TTRG_BIT])
      begin
        xfer_w[c] = q_reg.chan[c].pend;
      end
      else if (sel <= SEL_LAST)
      begin
        xfer_w[c] = edge_w[sel];
      end
      else
      begin
        xfer_w[c] = 1'b0;
      end
      // Output value loads only from the holding value
      if (xfer_w[c])
      begin
        q_next.chan[c].dout = q_reg.chan[c].hold;
        q_next.chan[c].pend = 1'b0;
        q_next.chan[c].rdy  = q_reg.chan[c].mode[MR_TTRG_BIT];
      end
      // Sticky event: a new transfer wins over a clear in the same clock
      q_next.chan[c].evt = q_reg.chan[c].evt | xfer_w[c];
      if (mine && q_reg.w_strb[0])
      begin
        if (woff == OFF_MODE)
        begin
          q_next.chan[c].mode = q_reg.w_data[MR_W-1:0];
          q_next.chan[c].rdy  = q_reg.w_data[MR_TTRG_BIT];
        end
        else if (woff == OFF_IEN)
        begin
          q_next.chan[c].mask = q_reg.chan[c].mask | q_reg.w_data[IM_W-1:0];
          ien_w[c] = q_reg.w_data[IM_RDY_BIT];
        end
        else if (woff == OFF_IDIS)
        begin
          q_next.chan[c].mask = q_reg.chan[c].mask & ~q_reg.w_data[IM_W-1:0];
        end
        else if (woff == OFF_EVENT)
        begin
          q_next.chan[c].evt = (q_reg.chan[c].evt & ~q_reg.w_data[0]) | xfer_w[c];
        end
        else if (woff == OFF_CMD)
        begin
          srst_w[c] = q_reg.w_data[CMD_SRST_BIT];
        end
      end
      // Holding value: byte lane in 8-bit mode, two lanes in 10-bit mode
      if (mine && (woff == OFF_HOLD) && (q_reg.w_strb[0] || q_reg.w_strb[1]))
      begin
        hold_wr_w[c] = 1'b1;
        if (q_reg.chan[c].mode[MR_RES_BIT])
        begin
          if (q_reg.w_strb[0])
          begin
            q_next.chan[c].hold = {q_reg.w_data[DATA_W-SHIFT8-1:0], SHIFT8'(0)};
          end
          else
          begin
            hold_wr_w[c] = 1'b0;
          end
        end
        else
        begin
          if (q_reg.w_strb[0])
          begin
            q_next.chan[c].hold[7:0] = q_reg.w_data[7:0];
          end
          if (q_reg.w_strb[1])
          begin
            q_next.chan[c].hold[DATA_W-1:8] = q_reg.w_data[DATA_W-1:8];
          end
        end
        if (hold_wr_w[c])
        begin
          // Auto mode copies next clock; trigger mode waits and shows pending
          q_next.chan[c].pend = !q_reg.chan[c].mode[MR_TTRG_BIT];
          q_next.chan[c].rdy  = 1'b0;
        end
      end
      if (srst_w[c])
      begin
        q_next.chan[c] = '0;
      end
      // Interrupt from next state so the pin lines up with the flags
      q_next.chan[c].irq = (q_next.chan[c].rdy && q_next.chan[c].mask[IM_RDY_BIT])
                         || (q_next.chan[c].evt && q_next.chan[c].mask[IM_EVT_BIT]);
    end

    // Read channel: data sampled from current state, no read side effects
    q_next.arready = i_s_axi_arvalid && !q_reg.rvalid && !q_reg.arready;
    if (q_reg.rvalid && i_s_axi_rready)
    begin
      q_next.rvalid = 1'b0;
    end
    if (roff == OFF_MODE)
    begin
      rval[MR_W-1:0] = q_reg.chan[rch].mode;
    end
    else if (roff == OFF_HOLD)
    begin
      rval[DATA_W-1:0] = q_reg.chan[rch].hold;
    end
    else if (roff == OFF_OUT)
    begin
      rval[DATA_W-1:0] = q_reg.chan[rch].dout;
    end
    else if (roff == OFF_STAT)
    begin
      rval[SR_RDY_BIT] = q_reg.chan[rch].rdy;
    end
    else if (roff == OFF_IMASK)
    begin
      rval[IM_W-1:0] = q_reg.chan[rch].mask;
    end
    else if (roff == OFF_EVENT)
    begin
      rval[0] = q_reg.chan[rch].evt;
    end
    else
    begin
      rval = '0;
    end
    if (i_s_axi_arvalid && q_reg.arready)
    begin
      q_next.rvalid = 1'b1;
      q_next.rdata  = rok ? rval : '0;
      q_next.rresp  = rok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_reg <= '0;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // Outputs straight from the state register
  assign o_dor0           = q_reg.chan[0].dout;
  assign o_dor1           = q_reg.chan[1].dout;
  assign o_converter0_irq = q_reg.chan[0].irq;
  assign o_converter1_irq = q_reg.chan[1].irq;
  assign o_s_axi_awready  = q_reg.awready;
  assign o_s_axi_wready   = q_reg.wready;
  assign o_s_axi_bvalid   = q_reg.bvalid;
  assign o_s_axi_bresp    = q_reg.bresp;
  assign o_s_axi_arready  = q_reg.arready;
  assign o_s_axi_rvalid   = q_reg.rvalid;
  assign o_s_axi_rdata    = q_reg.rdata;
  assign o_s_axi_rresp    = q_reg.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  write_resp_a: assert property (wr_go_w |=> o_s_axi_bvalid)
    else $error("write response not raised");
  read_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[AXI_DW-1:DATA_W] == '0)
    else $error("read data upper bits not zero");

  for (genvar g = 0; g < CONV_N; g++)
  begin : g_chk
    auto_copy_a: assert property (
      hold_wr_w[g] && !q_reg.chan[g].mode[MR_TTRG_BIT] && !srst_w[g]
      |=> xfer_w[g] ##1 q_reg.chan[g].dout == $past(q_reg.chan[g].hold))
      else $error("auto copy not one clock after write");
    out_hold_a: assert property (!xfer_w[g] && !srst_w[g]
      |=> $stable(q_reg.chan[g].dout))
      else $error("output value changed without transfer");
    rdy_auto_a: assert property (!q_reg.chan[g].mode[MR_TTRG_BIT]
      |-> !q_reg.chan[g].rdy)
      else $error("ready set while trigger disabled");
    trig_copy_a: assert property (
      q_reg.chan[g].mode[MR_TTRG_BIT] && xfer_w[g] && !hold_wr_w[g] && !srst_w[g] && !wr_go_w
      |=> q_reg.chan[g].rdy && q_reg.chan[g].dout == $past(q_reg.chan[g].hold))
      else $error("trigger edge did not copy");
    resv_sel_a: assert property (
      q_reg.chan[g].mode[MR_TTRG_BIT] && q_reg.chan[g].mode[MR_SEL_MSB:MR_SEL_LSB] > SEL_LAST
      |-> !xfer_w[g])
      else $error("reserved select caused a transfer");
    low_zero_a: assert property (hold_wr_w[g] && q_reg.chan[g].mode[MR_RES_BIT]
      && !srst_w[g] |=> q_reg.chan[g].hold[SHIFT8-1:0] == '0)
      else $error("8-bit value not shifted");
    irq_level_a: assert property (
      q_reg.chan[g].rdy && q_reg.chan[g].mask[IM_RDY_BIT] |-> q_reg.chan[g].irq)
      else $error("interrupt missing with ready and mask");
    soft_rst_a: assert property (srst_w[g]
      |=> q_reg.chan[g].mode == '0 && q_reg.chan[g].mask == '0 && !q_reg.chan[g].irq)
      else $error("soft reset did not clear converter");
    mask_set_a: assert property (ien_w[g] && !srst_w[g]
      |=> q_reg.chan[g].mask[IM_RDY_BIT])
      else $error("enable write did not set mask");
    auto_cov: cover property (hold_wr_w[g] && !q_reg.chan[g].mode[MR_TTRG_BIT] ##2 1);
    trig_cov: cover property (q_reg.chan[g].mode[MR_TTRG_BIT] && xfer_w[g]);
    irq_cov:  cover property ($rose(q_reg.chan[g].irq));
    srst_cov: cover property (srst_w[g]);
  end

endmodule : dhot_top

`default_nettype wire

// [hdl/dhot_pkg.sv]
// Shared constants for the converter holding/output trigger block
package dhot_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 10;    // Converter sample width
  localparam int          CONV_N     = 2;     // Identical converter instances
  localparam int          TIMER_N    = 6;     // Timer waveform outputs
  localparam int          MR_W       = 5;     // Live mode register bits
  localparam int          OFF_W      = 6;     // Offset bits inside one converter
  localparam int          CH_BIT     = 6;     // Address bit picking the converter
  localparam int          AXI_DW     = 32;    // Bus data width
  localparam int          AXI_SW     = 4;     // Bus strobe width

  // ----------------------------------------------------------------
  // Register offsets (byte addresses inside one converter window)
  // ----------------------------------------------------------------
  localparam logic [5:0]  OFF_CMD    = 6'h00; // converter_command
  localparam logic [5:0]  OFF_MODE   = 6'h04; // converter_mode
  localparam logic [5:0]  OFF_HOLD   = 6'h08; // holding_value
  localparam logic [5:0]  OFF_OUT    = 6'h0C; // output_value
  localparam logic [5:0]  OFF_STAT   = 6'h10; // converter_status
  localparam logic [5:0]  OFF_IEN    = 6'h14; // irq_enable_set
  localparam logic [5:0]  OFF_IDIS   = 6'h18; // irq_enable_clear
  localparam logic [5:0]  OFF_IMASK  = 6'h1C; // irq_mask_state
  localparam logic [5:0]  OFF_EVENT  = 6'h20; // transfer_event (sticky, write one to clear)

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          CMD_SRST_BIT = 0;   // soft_reset_cmd
  localparam int          MR_TTRG_BIT  = 0;   // timer_trigger_enable
  localparam int          MR_SEL_LSB   = 1;   // timer_trigger_select low bit
  localparam int          MR_SEL_MSB   = 3;   // timer_trigger_select high bit
  localparam int          MR_RES_BIT   = 4;   // resolution_select (1 = 8-bit)
  localparam int          SR_RDY_BIT   = 0;   // holding_value_consumed
  localparam int          IM_RDY_BIT   = 0;   // Mask for holding_value_consumed
  localparam int          IM_EVT_BIT   = 1;   // Mask for transfer event
  localparam int          IM_W         = 2;   // Mask width
  localparam int          SHIFT8       = 2;   // Left shift in 8-bit mode
  localparam logic [2:0]  SEL_LAST     = 3'h5; // Highest legal trigger select
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [5:0]  ALIGN_MASK   = 6'h03;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CORE_CLK_MHZ = 25;  // i_core_clk rate
  localparam int          STARTUP_US   = 5;   // Longest converter startup
  localparam int          STARTUP_CYC  = STARTUP_US * CORE_CLK_MHZ;

endpackage : dhot_pkg

// [verification/dhot_timer_model.sv]
// Timer channel stand-in that produces trigger waveforms for the converters
`timescale 1ns/1ps
`default_nettype none

module dhot_timer_model (
  input  wire logic       i_clk,    // Master clock
  input  wire logic       i_rst_n,  // Async reset, active low
  input  wire logic [5:0] i_fire,   // One-cycle request per channel
  output logic      [5:0] o_wave    // Waveform outputs, idle low
);
  logic [5:0] tail_reg;

  // Waveform mode: each request gives a two-cycle high pulse, so one rising edge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wave   <= 6'h00;
      tail_reg <= 6'h00;
    end
    else
    begin
      o_wave   <= i_fire | tail_reg;
      tail_reg <= i_fire;
    end
  end
endmodule : dhot_timer_model

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the two-converter holding/output block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dhot_pkg::*;
  logic              clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, irq0, irq1, isel;
  logic [6:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata, seed, rd_d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rd_r, wr_r;
  logic [5:0]        fire, wave;
  logic [DATA_W-1:0] out0, out1, osel;
  int                failures, samples_checked, cyc, c, v, s;
  int                m_out [2];
  int                offs [6] = '{4, 8, 12, 16, 28, 32};

  assign osel = (c == 1) ? out1 : out0;
  assign isel = (c == 1) ? irq1 : irq0;

  dhot_top uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_timer_wave_output_a(wave),
    .o_dor0(out0), .o_dor1(out1), .o_converter0_irq(irq0), .o_converter1_irq(irq1),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

  dhot_timer_model timer (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .o_wave(wave));

  // Xorshift source for sample values
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic conclude();
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input int off, input logic [31:0] d, input logic [3:0] st);
    @(posedge clk);
    awaddr  <= 7'(c * 64 + off);
    wdata   <= d;
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_r = bresp;
    bready <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input int off);
    @(posedge clk);
    araddr  <= 7'(c * 64 + off);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input string name, input int off, input int exp);
    rd(off);
    chk(name, rd_d, 32'(exp));
  endtask : rchk

  // One trigger request; the waveform edge lands a cycle later
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 6'h00;
    repeat (4) @(posedge clk);
  endtask : pulse

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard: the sequence needs a few thousand cycles at most
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    seed = 32'h0000EE6F;
    m_out = '{0, 0};
    c = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (STARTUP_CYC) @(posedge clk);
    for (c = 0; c < CONV_N; c++)
    begin
      foreach (offs[k]) rchk("reset value", offs[k], 0);
      wr(12, 32'h3FF, 4'hF);
      chk("output write resp", 32'(wr_r), 32'(RESP_OKAY));
      rchk("output write ignored", 12, 0);
      rd(36);
      chk("unmapped resp", 32'(rd_r), 32'(RESP_SLVERR));
      wr(36, 32'h3FF, 4'hF);
      chk("unmapped write resp", 32'(wr_r), 32'(RESP_SLVERR));
      repeat (3)
      begin
        v = int'(xs() & 32'h3FF);
        wr(8, 32'(v), 4'hF);
        m_out[c] = v;
        chk("auto output pin", 32'(osel), 32'(v));
        rchk("hold readback", 8, v);
        rchk("output readback", 12, v);
        rchk("ready trigger off", 16, 0);
      end
      wr(4, 32'h10, 4'hF);
      v = int'(xs() & 32'hFF);
      wr(8, 32'(v), 4'h1);
      m_out[c] = v << 2;
      chk("8-bit output pin", 32'(osel), 32'(v << 2));
      rchk("8-bit hold", 8, v << 2);
      rchk("mode 8-bit", 4, 'h10);
      for (s = 0; s < 8; s++)
      begin
        wr(4, 32'(s * 2 + 1), 4'hF);
        rchk("ready on enable", 16, 1);
        v = int'(xs() & 32'h3FF);
        wr(8, 32'(v), 4'h3);
        rchk("ready pending", 16, 0);
        pulse(6'h3F ^ 6'(1 << s));
        rchk("unselected timer", 12, m_out[c]);
        if (s < 6)
        begin
          pulse(6'(1 << s));
          m_out[c] = v;
        end
        rchk("triggered output", 12, m_out[c]);
        rchk("ready after trigger", 16, (s < 6) ? 1 : 0);
        chk("other converter", 32'((c == 1) ? out0 : out1), 32'(m_out[1 - c]));
      end
      wr(4, 32'h1, 4'hF);
      chk("irq masked", 32'(isel), 0);
      wr(20, 32'h1, 4'hF);
      rchk("mask set", 28, 1);
      chk("irq raised", 32'(isel), 1);
      v = int'(xs() & 32'h3FF);
      wr(8, 32'(v), 4'hF);
      chk("irq while pending", 32'(isel), 0);
      pulse(6'h01);
      chk("irq after transfer", 32'(isel), 1);
      wr(24, 32'h1, 4'hF);
      chk("irq disabled", 32'(isel), 0);
      rchk("mask clear", 28, 0);
      // Transfer event stays set until a one is written back to it
      rchk("event sticky", 32, 1);
      wr(20, 32'h2, 4'hF);
      chk("event irq", 32'(isel), 1);
      wr(32, 32'h1, 4'hF);
      chk("event irq cleared", 32'(isel), 0);
      rchk("event cleared", 32, 0);
      wr(0, 32'h0, 4'hF);
      rchk("command zero", 4, 1);
      wr(0, 32'h1, 4'hF);
      m_out[c] = 0;
      foreach (offs[k]) rchk("soft reset", offs[k], 0);
    end
    conclude();
  end
endmodule : tb_top

`default_nettype wire
